/* ldesp_pkg.sv */
// shared constants for both ends of the extended serial port
package ldesp_pkg;
    // data layout
    localparam int GS_W = 12;
    localparam int CH_N = 16;
    localparam int GS_FULL = 192;
    localparam int GS_HALF = 96;
    localparam int DC_FULL = 96;
    localparam int ST_W = 17;
    // half selection counts
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_LOW = 2'h1;
    localparam logic [1:0] SEL_HIGH = 2'h2;
    localparam logic [1:0] SEL_STEP = 2'h1;
    // register map, byte offsets on apb
    localparam int AW = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_LEN = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_TX = 8'h40;
    localparam logic [7:0] ADDR_RX = 8'h80;
    localparam int TX_WORDS = 6;
    // field positions
    localparam int CTRL_HALF_N = 0;
    localparam int CTRL_MODE_DC = 1;
    localparam int CTRL_BLANK = 2;
    localparam int CMD_SHIFT = 0;
    localparam int CMD_LATCH = 1;
    localparam int STAT_BUSY = 0;
    localparam logic [2:0] CTRL_RESET = 3'h5;
    localparam logic [7:0] LEN_RESET = 8'hC0;
    localparam logic [7:0] LEN_MAX = 8'hC0;
    // timing
    localparam int CLK_NS = 10;
    localparam int SCLK_HALF_NS = 40;
    localparam int PWM_COUNT_CLOCK_HALF_NS = 20;
    localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CLK_NS;
    localparam int PWM_COUNT_CLOCK_HALF_CYC = PWM_COUNT_CLOCK_HALF_NS / CLK_NS;
    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} ldesp_state_e;
endpackage

/* ldesp_if.sv */
// pin bundle between the controller and the led driver port
interface ldesp_if;
    logic shift_clock;
    logic serial_in;
    logic serial_out;
    logic latch_strobe;
    logic outputs_off;
    logic half_access_select_n;
    logic mode_dc;
    logic pwm_count_clock;
    modport device (
        input shift_clock,
        input serial_in,
        output serial_out,
        input latch_strobe,
        input outputs_off,
        input half_access_select_n,
        input mode_dc,
        input pwm_count_clock
    );
    modport ctrl (
        output shift_clock,
        output serial_in,
        input serial_out,
        output latch_strobe,
        output outputs_off,
        output half_access_select_n,
        output mode_dc,
        output pwm_count_clock
    );
endinterface

/* ldesp_ctrl.sv */
// controller end: apb registers driving the serial link
module ldesp_ctrl #(
    parameter int SCLK_HALF = ldesp_pkg::SCLK_HALF_CYC,
    parameter int PWM_COUNT_CLOCK_HALF = ldesp_pkg::PWM_COUNT_CLOCK_HALF_CYC
) (
    // clock, reset, freeze
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ldesp_pkg::AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link pins
    ldesp_if.ctrl link
);
    import ldesp_pkg::*;

    ldesp_state_e state_q;
    logic [2:0] ctrl_q;
    logic [7:0] len_q;
    logic [7:0] bit_q;
    logic [7:0] div_q;
    logic [7:0] gdiv_q;
    logic op_latch_q;
    logic [31:0] tx_q [TX_WORDS];
    logic [31:0] rx_q [TX_WORDS];
    logic so_s1_q, so_s2_q;
    logic sclk_q, sin_q, latch_q, blank_q, half_q, mode_q, pwm_count_clock_q;
    logic wr_en, rd_en, is_tx, is_rx, half_end, go_shift, go_latch;
    logic [2:0] widx;
    logic [31:0] rdata_d;
    logic err_d;

    ////////////////////////////////////////////////////////////////////////
    assign widx = paddr[4:2];
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable;
    assign is_tx = paddr[7:5] == ADDR_TX[7:5] && widx < 3'(TX_WORDS) && paddr[1:0] == 2'h0;
    assign is_rx = paddr[7:5] == ADDR_RX[7:5] && widx < 3'(TX_WORDS) && paddr[1:0] == 2'h0;
    assign go_shift = wr_en && paddr == ADDR_CMD && pwdata[CMD_SHIFT] && len_q != 8'h00;
    assign go_latch = wr_en && paddr == ADDR_CMD && pwdata[CMD_LATCH] && !pwdata[CMD_SHIFT];
    assign half_end = div_q == 8'(SCLK_HALF - 1);

    always_comb begin
        rdata_d = 32'h0000_0000;
        err_d = 1'b0;
        if (paddr == ADDR_CTRL) begin
            rdata_d = {29'h0000_0000, ctrl_q};
        end else if (paddr == ADDR_CMD) begin
            rdata_d = 32'h0000_0000;
        end else if (paddr == ADDR_LEN) begin
            rdata_d = {24'h00_0000, len_q};
        end else if (paddr == ADDR_STAT) begin
            rdata_d[STAT_BUSY] = state_q != ST_IDLE;
        end else if (is_tx) begin
            rdata_d = tx_q[widx];
        end else if (is_rx) begin
            rdata_d = rx_q[widx];
        end else begin
            err_d = 1'b1;
        end
    end

    // read data is prepared in the setup cycle so the answer has no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else if (ce) begin
            pready <= 1'b1;
            if (rd_en) begin
                prdata <= pwrite ? 32'h0000_0000 : rdata_d;
                pslverr <= err_d;
            end
        end
    end

    // blank starts high so no sink turns on before data is valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
            len_q <= LEN_RESET;
        end else if (ce && wr_en) begin
            if (paddr == ADDR_CTRL) begin
                ctrl_q <= pwdata[2:0];
            end
            if (paddr == ADDR_LEN) begin
                len_q <= pwdata[7:0] > LEN_MAX ? LEN_MAX : pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (ce && wr_en && is_tx) begin
            tx_q[widx] <= pwdata;
        end
    end

    // the synced echo lags two pclk, so a bit moved on the falling edge has
    // only settled at the next rising edge when SCLK_HALF is at least 3
    always_ff @(posedge pclk) begin
        if (ce && state_q == ST_LOW && half_end && !op_latch_q) begin
            rx_q[bit_q[7:5]][bit_q[4:0]] <= so_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial_out is a pin from the far side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            so_s1_q <= 1'b0;
            so_s2_q <= 1'b0;
        end else if (ce) begin
            so_s1_q <= link.serial_out;
            so_s2_q <= so_s1_q;
        end
    end

    // free-running pwm clock; its rate bounds the display update rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gdiv_q <= 8'h00;
            pwm_count_clock_q <= 1'b0;
        end else if (ce) begin
            if (gdiv_q == 8'(PWM_COUNT_CLOCK_HALF - 1)) begin
                gdiv_q <= 8'h00;
                pwm_count_clock_q <= !pwm_count_clock_q;
            end else begin
                gdiv_q <= gdiv_q + 8'h01;
            end
        end
    end

    // shift clock divided from pclk, pulsed only while busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            sclk_q <= 1'b0;
            sin_q <= 1'b0;
            latch_q <= 1'b0;
            blank_q <= CTRL_RESET[CTRL_BLANK];
            half_q <= CTRL_RESET[CTRL_HALF_N];
            mode_q <= CTRL_RESET[CTRL_MODE_DC];
            bit_q <= 8'h00;
            div_q <= 8'h00;
            op_latch_q <= 1'b0;
        end else if (ce) begin
            case (state_q)
                ST_IDLE: begin
                    // pins follow ctrl only while idle, so latch is low
                    blank_q <= ctrl_q[CTRL_BLANK];
                    half_q <= ctrl_q[CTRL_HALF_N];
                    mode_q <= ctrl_q[CTRL_MODE_DC];
                    div_q <= 8'h00;
                    if (go_shift) begin
                        bit_q <= len_q - 8'h01;
                        sin_q <= tx_q[3'((len_q - 8'h01) >> 5)][5'(len_q - 8'h01)];
                        op_latch_q <= 1'b0;
                        state_q <= ST_LOW;
                    end else if (go_latch) begin
                        // with blank high in extended mode each pulse steps the half choice, stopping at the high half
                        latch_q <= 1'b1;
                        op_latch_q <= 1'b1;
                        state_q <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    div_q <= half_end ? 8'h00 : div_q + 8'h01;
                    if (half_end) begin
                        sclk_q <= 1'b1;
                        state_q <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    div_q <= half_end ? 8'h00 : div_q + 8'h01;
                    if (half_end) begin
                        sclk_q <= 1'b0;
                        latch_q <= 1'b0;
                        if (op_latch_q || bit_q == 8'h00) begin
                            state_q <= ST_IDLE;
                        end else begin
                            bit_q <= bit_q - 8'h01;
                            sin_q <= tx_q[3'((bit_q - 8'h01) >> 5)][5'(bit_q - 8'h01)];
                            state_q <= ST_LOW;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign link.shift_clock = sclk_q;
    assign link.serial_in = sin_q;
    assign link.latch_strobe = latch_q;
    assign link.outputs_off = blank_q;
    assign link.half_access_select_n = half_q;
    assign link.mode_dc = mode_q;
    assign link.pwm_count_clock = pwm_count_clock_q;
endmodule

/* ldesp_device.sv */
// device end: led sink driver serial port with extended half access
module ldesp_device (
    // link pins
    ldesp_if.device link,
    // power-on reset and freeze
    input wire logic presetn,
    input wire logic ce,
    // fault flags from the sink stage
    input wire logic [ldesp_pkg::CH_N-1:0] lod_flags,
    input wire logic tef_flag,
    // latched words and sink drive
    output logic [ldesp_pkg::GS_FULL-1:0] gs_word,
    output logic [ldesp_pkg::DC_FULL-1:0] dc_word,
    output logic [ldesp_pkg::CH_N-1:0] sink_output
);
    import ldesp_pkg::*;

    logic ext_mode;
    logic ext_q;
    logic dc_q;
    logic blank_q;
    logic [1:0] sel_q;
    logic [1:0] sel_d;
    logic [GS_FULL-1:0] full_sr_q;
    logic [GS_HALF-1:0] half_sr_q;
    logic so_neg_q;
    logic [ST_W-1:0] st_s1_q;
    logic [ST_W-1:0] st_s2_q;
    logic bs1_q;
    logic bs2_q;
    logic [GS_W-1:0] pwm_cnt_q;
    logic [CH_N-1:0] lit;

    ////////////////////////////////////////////////////////////////////////
    // link pins change away from the rising edge, so they are this domain
    assign ext_mode = !link.half_access_select_n && !link.mode_dc;

    // fault flags are slow levels; two stages before use
    always_ff @(posedge link.shift_clock or negedge presetn) begin
        if (!presetn) begin
            st_s1_q <= '0;
            st_s2_q <= '0;
        end else if (ce) begin
            st_s1_q <= {tef_flag, lod_flags};
            st_s2_q <= st_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // half selection by latch pulses seen while blanked
    always_comb begin
        sel_d = sel_q;
        if (link.outputs_off && !blank_q) begin
            sel_d = SEL_NONE;
        end
        if (ext_mode && link.latch_strobe && link.outputs_off && sel_d != SEL_HIGH) begin
            sel_d = sel_d + SEL_STEP;
        end
    end

    always_ff @(posedge link.shift_clock or negedge presetn) begin
        if (!presetn) begin
            sel_q <= SEL_NONE;
            blank_q <= 1'b0;
            ext_q <= 1'b0;
            dc_q <= 1'b0;
        end else if (ce) begin
            sel_q <= sel_d;
            blank_q <= link.outputs_off;
            ext_q <= ext_mode;
            dc_q <= link.mode_dc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // normal shift path: 192 grayscale bits, or the low 96 for dot correction
    always_ff @(posedge link.shift_clock or negedge presetn) begin
        if (!presetn) begin
            full_sr_q <= '0;
        end else if (ce && !ext_mode) begin
            if (!link.latch_strobe) begin
                full_sr_q <= {full_sr_q[GS_FULL-2:0], link.serial_in};
            end else if (!link.mode_dc) begin
                // status rides ahead of the next frame
                full_sr_q <= {st_s2_q, {(GS_FULL - ST_W){1'b0}}};
            end else begin
                full_sr_q <= '0;
            end
        end
    end

    // extended shift path: one half, eight channels of twelve bits
    always_ff @(posedge link.shift_clock or negedge presetn) begin
        if (!presetn) begin
            half_sr_q <= '0;
        end else if (ce && ext_mode) begin
            if (!link.latch_strobe) begin
                half_sr_q <= {half_sr_q[GS_HALF-2:0], link.serial_in};
            end else if (link.outputs_off) begin
                if (sel_d == SEL_HIGH) begin
                    half_sr_q <= {st_s2_q, {(GS_HALF - ST_W){1'b0}}};
                end else begin
                    half_sr_q <= '0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // latch into the data words
    always_ff @(posedge link.shift_clock or negedge presetn) begin
        if (!presetn) begin
            gs_word <= '0;
            dc_word <= '0;
        end else if (ce && link.latch_strobe) begin
            if (ext_mode) begin
                // only the chosen half is loaded; the other keeps its value
                if (!link.outputs_off && sel_q == SEL_LOW) begin
                    gs_word[GS_HALF-1:0] <= half_sr_q;
                end else if (!link.outputs_off && sel_q == SEL_HIGH) begin
                    gs_word[GS_FULL-1:GS_HALF] <= half_sr_q;
                end
            end else if (link.mode_dc) begin
                dc_word <= full_sr_q[DC_FULL-1:0];
            end else begin
                gs_word <= full_sr_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // extended output moves half a clock later for long cables
    always_ff @(negedge link.shift_clock or negedge presetn) begin
        if (!presetn) begin
            so_neg_q <= 1'b0;
        end else if (ce) begin
            so_neg_q <= half_sr_q[GS_HALF-1];
        end
    end

    // the select flop only changes on a rising edge, away from the falling one
    assign link.serial_out = ext_q ? so_neg_q
                           : (dc_q ? full_sr_q[DC_FULL-1] : full_sr_q[GS_FULL-1]);

    ////////////////////////////////////////////////////////////////////////
    // pwm stage on its own clock; blanking passes two stages first
    always_ff @(posedge link.pwm_count_clock or negedge presetn) begin
        if (!presetn) begin
            bs1_q <= 1'b1;
            bs2_q <= 1'b1;
        end else if (ce) begin
            bs1_q <= link.outputs_off;
            bs2_q <= bs1_q;
        end
    end

    // a full count of 4096 steps makes one grayscale period
    always_ff @(posedge link.pwm_count_clock or negedge presetn) begin
        if (!presetn) begin
            pwm_cnt_q <= '0;
        end else if (ce) begin
            if (bs2_q) begin
                pwm_cnt_q <= '0;
            end else begin
                pwm_cnt_q <= pwm_cnt_q + GS_W'(1);
            end
        end
    end

    // grayscale words are treated as quasi-static here: a latch while unblanked
    // may disturb one pwm period, which the display cannot show
    for (genvar i = 0; i < CH_N; i++) begin : g_sink
        assign lit[i] = pwm_cnt_q < gs_word[i*GS_W +: GS_W];
    end

    always_ff @(posedge link.pwm_count_clock or negedge presetn) begin
        if (!presetn) begin
            sink_output <= '0;
        end else if (ce) begin
            sink_output <= bs2_q ? '0 : lit;
        end
    end
endmodule

/* ldesp_assertions.sv */
// link pin checker placed beside the controller to driver interface
module ldesp_assertions #(
    parameter int SCLK_HALF = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // link pins
    input wire logic shift_clock,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic latch_strobe,
    input wire logic outputs_off,
    input wire logic half_access_select_n,
    input wire logic mode_dc,
    input wire logic pwm_count_clock
);
    logic [1:0] age_q;
    logic [7:0] lat_cnt_q;
    logic [1:0] lat_edges_q;
    logic sel_seen_q;
    logic ext;
    assign ext = !half_access_select_n && !mode_dc;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    // output mux settles only at a shift edge after a mode change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) age_q <= 2'h0;
        else if ($changed({half_access_select_n, mode_dc})) age_q <= 2'h0;
        else if ($rose(shift_clock) && age_q != 2'h3) age_q <= age_q + 2'h1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) lat_cnt_q <= 8'h00;
        else if (latch_strobe) lat_cnt_q <= lat_cnt_q + 8'h01;
        else lat_cnt_q <= 8'h00;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) lat_edges_q <= 2'h0;
        else if (!latch_strobe) lat_edges_q <= 2'h0;
        else if ($rose(shift_clock) && lat_edges_q != 2'h3) lat_edges_q <= lat_edges_q + 2'h1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sel_seen_q <= 1'b0;
        else if ($rose(outputs_off)) sel_seen_q <= 1'b0;
        else if ($rose(latch_strobe) && outputs_off) sel_seen_q <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    ext_out_fall_a: assert property (
        ext && age_q >= 2'h2 && $changed(serial_out) |-> $fell(shift_clock))
        else $error("serial out moved off a falling shift edge in extended mode");
    norm_out_rise_a: assert property (
        half_access_select_n && age_q >= 2'h2 && $changed(serial_out) |-> $rose(shift_clock))
        else $error("serial out moved off a rising shift edge in normal mode");
    dc_out_rise_a: assert property (
        !half_access_select_n && mode_dc && age_q >= 2'h2 && $changed(serial_out)
        |-> $rose(shift_clock))
        else $error("serial out moved off a rising shift edge in dot correction mode");
    mode_latch_low_a: assert property (
        $changed(mode_dc) |-> !latch_strobe && !$past(latch_strobe))
        else $error("mode changed while latch strobe high");
    power_blank_a: assert property (
        !$past(presetn) |-> outputs_off)
        else $error("outputs not blanked after power-on");
    latch_width_a: assert property (
        $fell(latch_strobe) |-> lat_cnt_q == 8'(2 * SCLK_HALF))
        else $error("latch strobe width not one shift period");
    latch_one_edge_a: assert property (
        $fell(latch_strobe) |-> lat_edges_q == 2'h1)
        else $error("latch strobe did not span exactly one rising shift edge");
    sin_setup_a: assert property (
        $changed(serial_in) |-> !shift_clock)
        else $error("serial in changed while shift clock high");
    select_first_a: assert property (
        ext && $rose(shift_clock) && !latch_strobe |-> sel_seen_q)
        else $error("data shifted in extended mode before a half was selected");
endmodule

/* testbench.sv */
// testbench joining controller and driver ends, driven over apb
`define CHK(nm, ex, gt) \
    begin \
        check_count++; \
        if ((gt) !== (ex)) begin \
            miscompares++; \
            $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); \
        end \
    end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ldesp_pkg::*;
    localparam logic [95:0] LO = 96'h123456789ABCDEF013579BDF;
    localparam logic [95:0] HI = 96'hFEDCBA9876543210ECA86420;
    localparam logic [95:0] LO2 = 96'h0F1E2D3C4B5A69788796A5B4;
    localparam logic [95:0] DC = 96'hC3A55A3C96E10F87D2B44B2D;
    localparam logic [191:0] FULL = {HI ^ LO2, DC ^ LO};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tef_flag, slv;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] lod_flags, sink_output;
    logic [191:0] gs_word, rx;
    logic [95:0] dc_word;
    int miscompares, check_count;
    ldesp_if link_if();
    // sclk_half below 3 would let the synced echo miss the delayed output bit
    ldesp_ctrl #(.SCLK_HALF(SCLK_HALF_CYC), .PWM_COUNT_CLOCK_HALF(1)) i_ldesp_ctrl (.pclk(pclk),
        .presetn(presetn),
        .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_if));
    ldesp_device i_ldesp_device (.link(link_if), .presetn(presetn), .ce(1'b1),
        .lod_flags(lod_flags), .tef_flag(tef_flag), .gs_word(gs_word), .dc_word(dc_word),
        .sink_output(sink_output));
    ldesp_assertions #(.SCLK_HALF(SCLK_HALF_CYC)) i_ldesp_assertions (.pclk(pclk),
        .presetn(presetn),
        .shift_clock(link_if.shift_clock), .serial_in(link_if.serial_in),
        .serial_out(link_if.serial_out), .latch_strobe(link_if.latch_strobe),
        .outputs_off(link_if.outputs_off), .half_access_select_n(link_if.half_access_select_n),
        .mode_dc(link_if.mode_dc), .pwm_count_clock(link_if.pwm_count_clock));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // one apb transfer; waits for pready but never past the bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            finish_test();
        end
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        apb(1'b1, a, d, t);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        apb(1'b0, a, 32'h0, d);
    endtask
    task automatic cmd(input logic [31:0] c);
        logic [31:0] s;
        int n;
        wr(ADDR_CMD, c);
        n = 0;
        do begin
            rd(ADDR_STAT, s);
            n++;
        end while (s[STAT_BUSY] !== 1'b0 && n < 1000);
        if (n >= 1000) begin
            miscompares++;
            finish_test();
        end
    endtask
    task automatic shift(input logic [191:0] tx, input logic [7:0] len);
        for (int i = 0; i < TX_WORDS; i++) wr(ADDR_TX + 8'(i * 4), tx[32 * i +: 32]);
        wr(ADDR_LEN, {24'h0, len});
        cmd(32'h1);
        for (int i = 0; i < TX_WORDS; i++) rd(ADDR_RX + 8'(i * 4), rx[32 * i +: 32]);
    endtask
    // pins follow the control register only while the link is idle
    task automatic latch(input logic [31:0] ctl);
        wr(ADDR_CTRL, ctl);
        cmd(32'h2);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        logic [31:0] d;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        lod_flags = 16'hA5C3;
        tef_flag = 1'b1;
        miscompares = 0;
        check_count = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(ADDR_CTRL, d);
        `CHK("ctrl reset", 32'h5, d);
        rd(ADDR_LEN, d);
        `CHK("len reset", 32'hC0, d);
        wr(ADDR_LEN, 32'hFF);
        rd(ADDR_LEN, d);
        `CHK("len clamp", 32'hC0, d);
        rd(8'h30, d);
        `CHK("unmapped error", 1'b1, slv);
        `CHK("blank sinks", 16'h0, sink_output);
        latch(32'h4);
        shift({96'h0, LO}, 8'h60);
        `CHK("low half echo", 96'h0, rx[95:0]);
        latch(32'h0);
        `CHK("low half load", LO, gs_word[95:0]);
        `CHK("high half kept", 96'h0, gs_word[191:96]);
        latch(32'h4);
        latch(32'h4);
        shift({96'h0, HI}, 8'h60);
        `CHK("status high half", {tef_flag, lod_flags}, rx[95:79]);
        `CHK("status pad", 79'h0, rx[78:0]);
        latch(32'h0);
        `CHK("high half load", HI, gs_word[191:96]);
        `CHK("low half kept", LO, gs_word[95:0]);
        // blanking rises again, so one pulse must mean the low half
        latch(32'h4);
        shift({96'h0, LO2}, 8'h60);
        latch(32'h0);
        `CHK("reselect low", {HI, LO2}, gs_word);
        wr(ADDR_CTRL, 32'h6);
        shift({96'h0, DC}, 8'h60);
        cmd(32'h2);
        `CHK("dot correction", DC, dc_word);
        `CHK("grayscale untouched", {HI, LO2}, gs_word);
        `CHK("blank sinks dc", 16'h0, sink_output);
        wr(ADDR_CTRL, 32'h5);
        shift(FULL, 8'hC0);
        cmd(32'h2);
        `CHK("normal load", FULL, gs_word);
        shift(192'h0, 8'hC0);
        `CHK("normal status", {tef_flag, lod_flags}, rx[191:175]);
        // every channel of FULL is at least 0F2, so early in the period all sinks are on
        wr(ADDR_CTRL, 32'h1);
        repeat (40) @(posedge pclk);
        `CHK("sinks lit", 16'hFFFF, sink_output);
        wr(ADDR_CTRL, 32'h5);
        repeat (40) @(posedge pclk);
        `CHK("sinks reblanked", 16'h0, sink_output);
        finish_test();
    end
endmodule
